// >>> rtl/chopper_cfg.svh
// timing constants for the constant off-time current chopper
// assumes a single block clock; all counts derive from its period
`ifndef CHOPPER_CFG_SVH
`define CHOPPER_CFG_SVH

// block clock period in ns (10 MHz)
`define CHOP_CLK_NS 100
// cross-conduction gap, ns
`define CHOP_DEADTIME_NS 1000
// comparator mask interval after switch-on, ns
`define CHOP_BLANK_NS 1000
// minimum on time, ns
`define CHOP_MINON_NS 2500
// least times round up to whole cycles
`define CHOP_DT_CYC ((`CHOP_DEADTIME_NS + `CHOP_CLK_NS - 1) / `CHOP_CLK_NS)
`define CHOP_BLANK_CYC ((`CHOP_BLANK_NS + `CHOP_CLK_NS - 1) / `CHOP_CLK_NS)
`define CHOP_MINON_CYC ((`CHOP_MINON_NS + `CHOP_CLK_NS - 1) / `CHOP_CLK_NS)
// supported off period span, ns (kept by the configuring party)
`define CHOP_OFF_MIN_NS 6600
`define CHOP_OFF_MAX_NS 6000000
`define CHOP_OFF_DEF_CYC ((`CHOP_OFF_MIN_NS + `CHOP_CLK_NS - 1) / `CHOP_CLK_NS)

`endif

// >>> rtl/chopper_pkg.sv
// types shared by the chopper and its leg selector
// assumes nothing beyond the timing header
package chopper_pkg;
   // one bit per bridge leg
   typedef logic [2:0] leg_t;
   // bridge sequencing states
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_GAP = 3'b001,
      ST_ON = 3'b010,
      ST_DEAD_OFF = 3'b011,
      ST_RECIRC = 3'b100,
      ST_DEAD_ON = 3'b101
   } state_t;
endpackage

// >>> rtl/leg_select.sv
// leg selector: turns the hall code and direction into a source and a sink leg
// assumes inputs already synchronised to clk
`timescale 1ns/10ps
`default_nettype none
module leg_select
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // position and direction
   input wire logic [2:0] hall_code,
   input wire logic direction_select,
   // chosen legs, one-hot
   output chopper_pkg::leg_t src_leg,
   output chopper_pkg::leg_t sink_leg
);
   import chopper_pkg::*;

   leg_t next_src_leg;
   leg_t next_sink_leg;
   leg_t fwd_src;
   leg_t fwd_sink;

   ////////////////////////////////////////////////////////////////
   // one output configuration per hall code, swapped for reverse
   always_comb
   begin
      unique case (hall_code) // RULE14
         3'h4:
         begin
            fwd_src = 3'h1;
            fwd_sink = 3'h4;
         end
         3'h6:
         begin
            fwd_src = 3'h2;
            fwd_sink = 3'h4;
         end
         3'h2, 3'h7:
         begin
            fwd_src = 3'h2;
            fwd_sink = 3'h1;
         end
         3'h3:
         begin
            fwd_src = 3'h4;
            fwd_sink = 3'h1;
         end
         3'h1:
         begin
            fwd_src = 3'h4;
            fwd_sink = 3'h2;
         end
         3'h5, 3'h0:
         begin
            fwd_src = 3'h1;
            fwd_sink = 3'h2;
         end
      endcase
      next_src_leg = direction_select ? fwd_src : fwd_sink;
      next_sink_leg = direction_select ? fwd_sink : fwd_src;
   end

   // register the selection
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         src_leg <= 3'h0;
         sink_leg <= 3'h0;
      end
      else
      begin
         src_leg <= next_src_leg;
         sink_leg <= next_sink_leg;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/current_chopper.sv
// constant off-time current chopper for a three-phase half-bridge stage
// assumes pin inputs are asynchronous; off_time_cycles is static config on clk
`timescale 1ns/10ps
`default_nettype none
`include "chopper_cfg.svh"

// Summary of operation
// RULE1 - gap between switches of one leg
// RULE2 - sense over limit starts off period
// RULE3 - off period recirculates through upper half
// RULE4 - monostable expiry restores conducting legs
// RULE5 - off period is monostable plus gap
// RULE6 - comparator masked after each switch-on
// RULE7 - minimum on time before next off
// RULE8 - configurer keeps off time in span
// RULE9 - short on time still operates safely
// RULE10 - two legs active, third fully off
// RULE11 - off period starts with low side off
// RULE12 - upper rectifier on after one gap
// RULE13 - rectifier off, low side after gap
// RULE14 - legs chosen from hall decoder
// RULE15 - enable low holds all switches off
// RULE16 - timings are clock cycle counters
module current_chopper
#(
   parameter int OFF_W = 16
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pins from outside
   input wire logic enable,
   input wire logic current_limit,
   input wire logic hall_input_1,
   input wire logic hall_input_2,
   input wire logic hall_input_3,
   input wire logic direction_select,
   // monostable period, in clk cycles; off period adds one gap
   input wire logic [OFF_W-1:0] off_time_cycles,
   // gate commands, one bit per leg
   output logic [2:0] high_gate,
   output logic [2:0] low_gate
);
   import chopper_pkg::*;

   localparam logic [7:0] DT_CYC = 8'(`CHOP_DT_CYC);
   localparam logic [7:0] BLANK_CYC = 8'(`CHOP_BLANK_CYC);
   localparam logic [7:0] MINON_CYC = 8'(`CHOP_MINON_CYC);

   logic [5:0] sync1;
   logic [5:0] sync2;
   logic en_s;
   logic sense_s;
   leg_t src_leg;
   leg_t sink_leg;
   leg_t act_src;
   leg_t act_sink;
   leg_t next_act_src;
   leg_t next_act_sink;
   state_t state;
   state_t next_state;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic [OFF_W-1:0] mono_cnt;
   logic [OFF_W-1:0] next_mono_cnt;
   logic [2:0] next_high_gate;
   logic [2:0] next_low_gate;
   logic legs_moved;
   logic mono_done;
   logic trig_ok;

   // larger of two counts
   function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
      max8 = (a > b) ? a : b;
   endfunction

   ////////////////////////////////////////////////////////////////
   // two-flop synchronisers for all pin inputs
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
      end
      else
      begin
         sync1 <= {enable, current_limit, hall_input_1, hall_input_2, hall_input_3, direction_select};
         sync2 <= sync1;
      end
   end

   assign en_s = sync2[5];
   assign sense_s = sync2[4];

   // hall decode into source and sink legs
   leg_select u_leg_select
   (
      .clk(clk),
      .rst(rst),
      .hall_code(sync2[3:1]),
      .direction_select(sync2[0]),
      .src_leg(src_leg),
      .sink_leg(sink_leg)
   );

   ////////////////////////////////////////////////////////////////
   // sequencer: next state, counters and gate pattern
   assign legs_moved = (src_leg != act_src) || (sink_leg != act_sink);
   assign mono_done = (mono_cnt[OFF_W-1:1] == '0); // RULE5 last monostable cycle, so off = mono plus one gap
   // mask interval and minimum on time both gate the comparator
   assign trig_ok = (cnt >= max8(BLANK_CYC, MINON_CYC)); // RULE6 RULE7

   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      next_act_src = act_src;
      next_act_sink = act_sink;
      // monostable runs down from its trigger, independent of the gap
      next_mono_cnt = mono_done ? mono_cnt : mono_cnt - 1'b1; // RULE16
      if (!en_s)
      begin
         next_state = ST_IDLE; // RULE15
         next_cnt = 8'h00;
      end
      else if (legs_moved || state == ST_IDLE)
      begin
         // commutation: everything off for one gap, then new legs
         next_act_src = src_leg; // RULE14
         next_act_sink = sink_leg;
         next_state = ST_GAP; // RULE1
         next_cnt = 8'h00;
      end
      else
      begin
         unique case (state)
            ST_IDLE, ST_GAP:
            begin
               next_cnt = cnt + 8'h01;
               if (cnt == DT_CYC - 8'h01)
               begin
                  next_state = ST_ON;
                  next_cnt = 8'h00;
               end
            end
            ST_ON:
            begin
               if (cnt != 8'hFF)
                  next_cnt = cnt + 8'h01;
               if (sense_s && trig_ok)
               begin
                  next_state = ST_DEAD_OFF; // RULE2 RULE11
                  next_cnt = 8'h00;
                  next_mono_cnt = off_time_cycles; // RULE8
               end
            end
            ST_DEAD_OFF:
            begin
               next_cnt = cnt + 8'h01;
               if (cnt == DT_CYC - 8'h01)
               begin
                  // an already expired monostable skips straight to the closing gap
                  next_state = mono_done ? ST_DEAD_ON : ST_RECIRC; // RULE12 RULE9
                  next_cnt = 8'h00;
               end
            end
            ST_RECIRC:
            begin
               if (mono_done)
               begin
                  next_state = ST_DEAD_ON; // RULE4 RULE13
                  next_cnt = 8'h00;
               end
            end
            ST_DEAD_ON:
            begin
               next_cnt = cnt + 8'h01;
               if (cnt == DT_CYC - 8'h01)
               begin
                  // gap after expiry makes off period monostable plus gap
                  next_state = ST_ON; // RULE5 RULE13
                  next_cnt = 8'h00;
               end
            end
            default:
            begin
               next_state = ST_IDLE;
               next_cnt = 8'h00;
            end
         endcase
      end
      // gate pattern follows the next state; unused leg stays off
      next_high_gate = 3'h0; // RULE10
      next_low_gate = 3'h0;
      unique case (next_state)
         ST_ON:
         begin
            next_high_gate = next_act_src;
            next_low_gate = next_act_sink;
         end
         ST_DEAD_OFF, ST_DEAD_ON:
            next_high_gate = next_act_src; // RULE11
         ST_RECIRC:
            next_high_gate = next_act_src | next_act_sink; // RULE3 RULE12
         default:
         begin
            next_high_gate = 3'h0;
            next_low_gate = 3'h0;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state <= ST_IDLE;
         cnt <= 8'h00;
         mono_cnt <= '0;
         act_src <= 3'h0;
         act_sink <= 3'h0;
         high_gate <= 3'h0;
         low_gate <= 3'h0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         mono_cnt <= next_mono_cnt;
         act_src <= next_act_src;
         act_sink <= next_act_sink;
         high_gate <= next_high_gate;
         low_gate <= next_low_gate;
      end
   end

   ////////////////////////////////////////////////////////////////
   // checks on the gate sequencing
   no_shoot_thru_a: assert property (@(posedge clk) disable iff (rst) // RULE1
      (high_gate & low_gate) == 3'h0)
      else $error("both switches of one leg on");

   one_leg_idle_a: assert property (@(posedge clk) disable iff (rst) // RULE10
      $countones(high_gate | low_gate) <= 2)
      else $error("more than two legs active");

   low_off_gap_a: assert property (@(posedge clk) disable iff (rst) // RULE13
      (state == ST_DEAD_ON) && (cnt == DT_CYC - 8'h01) && en_s && !legs_moved
      |=> (state == ST_ON) && (low_gate == act_sink))
      else $error("low side not back on after gap");

   rectifier_gap_a: assert property (@(posedge clk) disable iff (rst) // RULE12
      (state == ST_RECIRC) && ($past(state) == ST_DEAD_OFF) |-> $past(cnt) == DT_CYC - 8'h01)
      else $error("rectifier switched on before one gap");

   blank_mask_a: assert property (@(posedge clk) disable iff (rst) // RULE6
      (state == ST_ON) && (cnt < BLANK_CYC) |=> state != ST_DEAD_OFF)
      else $error("comparator honoured during mask");

   min_on_a: assert property (@(posedge clk) disable iff (rst) // RULE7
      $rose(state == ST_DEAD_OFF) |-> $past(cnt) >= MINON_CYC)
      else $error("off period before minimum on time");

   trigger_off_a: assert property (@(posedge clk) disable iff (rst) // RULE2
      (state == ST_ON) && sense_s && trig_ok && en_s && !legs_moved
      |=> (state == ST_DEAD_OFF) && (low_gate == 3'h0) && (high_gate == act_src))
      else $error("over-limit did not end on time");

   recirc_pattern_a: assert property (@(posedge clk) disable iff (rst) // RULE3
      state == ST_RECIRC |-> (high_gate == (act_src | act_sink)) && (low_gate == 3'h0))
      else $error("wrong recirculation pattern");

   on_pattern_a: assert property (@(posedge clk) disable iff (rst) // RULE4
      state == ST_ON |-> (high_gate == act_src) && (low_gate == act_sink))
      else $error("wrong conducting pattern");

   enable_off_a: assert property (@(posedge clk) disable iff (rst) // RULE15
      !en_s |=> (high_gate == 3'h0) && (low_gate == 3'h0))
      else $error("switch on while disabled");

   // main scenarios
   chop_cycle_c: cover property (@(posedge clk) disable iff (rst)
      (state == ST_RECIRC) ##1 (state == ST_DEAD_ON) ##10 (state == ST_ON));
   short_off_c: cover property (@(posedge clk) disable iff (rst)
      (state == ST_DEAD_OFF) ##1 (state == ST_DEAD_ON));
   commutate_c: cover property (@(posedge clk) disable iff (rst)
      (state == ST_ON) ##1 (state == ST_GAP));
endmodule
`default_nettype wire

// >>> sim/bridge_model.sv
// behavioural bridge, sense resistor and winding seen by the chopper
// assumes gate commands are active high, one bit per leg
`timescale 1ns/10ps
`default_nettype none
module bridge_model
#(
   parameter int LIMIT = 60
)
(
   // clock
   input wire logic clk,
   // gate commands
   input wire logic [2:0] high_gate,
   input wire logic [2:0] low_gate,
   // sense comparator
   output logic current_limit
);
   int cur = 0;
   int since_on = 0;
   int tick = 0;

   // winding current: rises when driven, decays slowly through the upper half, collapses when all off
   always @(posedge clk)
   begin
      tick <= tick + 1;
      if (low_gate == 3'h0)
      begin
         since_on <= 0;
         if (high_gate == 3'h0)
            cur <= 0;
         else if (tick % 8 == 0 && cur > 0)
            cur <= cur - 1;
      end
      else
      begin
         since_on <= since_on + 1;
         if ((high_gate & ~low_gate) != 3'h0)
            cur <= cur + 1;
      end
   end

   // diode recovery spike for 3 cycles after switch-on, then the real trip
   assign current_limit = (cur >= LIMIT) || (low_gate != 3'h0 && since_on < 3);
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the current chopper
// assumes the bridge model closes the current loop
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic enable = 1'b0;
   logic current_limit;
   logic [2:0] hall = 3'h4;
   logic dir = 1'b1;
   logic [15:0] off_time = 16'h0042;
   logic [2:0] high_gate;
   logic [2:0] low_gate;
   int err_total = 0;
   int n_checks = 0;
   int cycles = 0;
   int n;
   localparam logic [2:0] SRC [8] = '{3'h1, 3'h4, 3'h2, 3'h4, 3'h1, 3'h1, 3'h2, 3'h2};
   localparam logic [2:0] SNK [8] = '{3'h2, 3'h2, 3'h1, 3'h1, 3'h4, 3'h2, 3'h4, 3'h1};

   ////////////////////////////////////////////////////////////////
   // design, far side and clock
   current_chopper #(.OFF_W(16)) DUT
   (
      .clk(clk),
      .rst(rst),
      .enable(enable),
      .current_limit(current_limit),
      .hall_input_1(hall[2]),
      .hall_input_2(hall[1]),
      .hall_input_3(hall[0]),
      .direction_select(dir),
      .off_time_cycles(off_time),
      .high_gate(high_gate),
      .low_gate(low_gate)
   );
   bridge_model #(.LIMIT(60)) bridge
   (
      .clk(clk),
      .high_gate(high_gate),
      .low_gate(low_gate),
      .current_limit(current_limit)
   );
   always #50 clk = ~clk;

   ////////////////////////////////////////////////////////////////
   // compares and waits
   task automatic chk_pat(input logic [2:0] got, input logic [2:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi)
      begin
         err_total++;
         $display("Error at %0t: got %0h expected %0h..%0h", $time, got, lo, hi);
      end
   endtask

   // cycles until the gates show a pattern, limit+1 if never
   task automatic wait_pat(input logic [2:0] h, input logic [2:0] l, input int limit, output int c);
      c = 0;
      do
      begin
         @(negedge clk);
         c++;
      end
      while (!(high_gate === h && low_gate === l) && c <= limit);
   endtask

   task automatic end_of_test;
      if (err_total == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   // scenarios
   task automatic chop_test;
      int t_on, t_dead, t_rec, t_back, t_min;
      wait_pat(3'h1, 3'h0, 100, t_on);
      chk_cnt(t_on, 58, 68);
      wait_pat(3'h5, 3'h0, 20, t_dead);
      chk_cnt(t_dead, 10, 11);
      wait_pat(3'h1, 3'h0, 100, t_rec);
      wait_pat(3'h1, 3'h4, 20, t_back);
      chk_cnt(t_back, 10, 11);
      chk_cnt(t_dead + t_rec + t_back, 76, 76);
      wait_pat(3'h1, 3'h0, 40, t_min);
      chk_cnt(t_min, 25, 29);
   endtask

   task automatic hall_test;
      int g;
      logic [2:0] h;
      for (int i = 0; i < 16; i++)
      begin
         // reverse pass starts at code 4 so no two steps in a row keep the same legs
         h = i[2:0] ^ {i[3], 2'b00};
         @(posedge clk);
         hall <= h;
         dir <= ~i[3];
         wait_pat(3'h0, 3'h0, 8, g);
         chk_cnt(g, 1, 8);
         wait_pat(i < 8 ? SRC[h] : SNK[h], i < 8 ? SNK[h] : SRC[h], 20, g);
         chk_cnt(g, 10, 11);
      end
   endtask

   task automatic enable_test;
      int g, bad;
      @(posedge clk);
      enable <= 1'b0;
      wait_pat(3'h0, 3'h0, 5, g);
      chk_cnt(g, 1, 5);
      bad = 0;
      repeat (20)
      begin
         @(negedge clk);
         if (high_gate !== 3'h0 || low_gate !== 3'h0)
            bad++;
      end
      chk_cnt(bad, 0, 0);
      @(posedge clk);
      enable <= 1'b1;
      wait_pat(3'h1, 3'h4, 30, g);
      chk_cnt(g, 12, 20);
   endtask

   ////////////////////////////////////////////////////////////////
   // shoot-through watch and timeout
   always @(negedge clk)
   begin
      cycles++;
      if (!rst)
         chk_pat(high_gate & low_gate, 3'h0);
      if (cycles == 5000)
      begin
         err_total++;
         end_of_test;
      end
   end

   // main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      chk_pat(high_gate | low_gate, 3'h0);
      rst <= 1'b0;
      enable <= 1'b1;
      wait_pat(3'h1, 3'h4, 40, n);
      chk_cnt(n, 12, 20);
      chop_test;
      hall_test;
      enable_test;
      end_of_test;
   end
endmodule
`default_nettype wire
